// ===== host_ctrl_model.sv
// Behavioural host controller that drives the drive's discrete input pins.
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model (
  input  wire logic       ref_clk,
  input  wire logic [1:0] limit_high,
  input  wire logic       alt_req,
  input  wire logic       clear_req,
  input  wire logic       cause_active,
  output logic            fwd_limit_select_n,
  output logic            rev_limit_select_n,
  output logic            mode_switch_n,
  output logic            fault_clear_n
);
  initial begin
    fwd_limit_select_n = 1'b1;
    rev_limit_select_n = 1'b1;
    mode_switch_n      = 1'b1;
    fault_clear_n      = 1'b1;
  end
  always @(posedge ref_clk) begin
    fwd_limit_select_n <= limit_high[1];
    rev_limit_select_n <= limit_high[0];
    mode_switch_n      <= ~alt_req;
    // A clear request is held back while the fault cause is still present.
    fault_clear_n      <= ~(clear_req & ~cause_active);
  end
endmodule
`default_nettype wire

// ===== servo_io_pkg.sv
// Shared constants for the servo mode and status logic, plus the pin input synchroniser.
`timescale 1ns/10ps
`default_nettype none
package servo_io_pkg;
  localparam int unsigned SPEED_W        = 16;
  localparam int unsigned THRESH_W       = 12;
  localparam logic [11:0] THRESH_MAX     = 12'hbb8;
  localparam logic [11:0] THRESH_DEFAULT = 12'h014;
  localparam logic [3:0]  DIGIT_SPD_SPD  = 4'h4;
  localparam logic [3:0]  DIGIT_SPD_POS  = 4'h5;
  localparam logic [3:0]  DIGIT_SPD_TRQ  = 4'h6;
  localparam logic [3:0]  DIGIT_POS_SPD  = 4'h7;
  localparam logic [3:0]  DIGIT_POS_TRQ  = 4'h8;
  localparam logic [3:0]  DIGIT_TRQ_SPD  = 4'h9;
  localparam logic [3:0]  DIGIT_SPD_ZCL  = 4'ha;
  localparam logic [3:0]  DIGIT_POS_INH  = 4'hb;
  localparam logic [3:0]  DIGIT_POS_CON  = 4'hc;
  localparam logic [3:0]  DIGIT_SPD_PAR  = 4'hd;
  localparam logic [3:0]  DIGIT_SPECIAL  = 4'he;

  typedef enum logic [3:0] {
    MODE_SPEED_CONTACT,
    MODE_SPEED_ANALOG,
    MODE_POSITION_PULSE,
    MODE_TORQUE_ANALOG,
    MODE_ZERO_CLAMP,
    MODE_POSITION_INHIBIT,
    MODE_POSITION_CONTACT,
    MODE_SPEED_PARAM,
    MODE_SPECIAL,
    MODE_OTHER
  } ctrl_mode_e;
endpackage

module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] out_d;

  // A bit moves only once the second and third stages agree, which rejects
  // a single-cycle glitch on the pin. Idle level of every pin is high.
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1_q  <= '1;
      s2_q  <= '1;
      s3_q  <= '1;
      out_q <= '1;
    end else begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign pin_out = out_q;
endmodule
`default_nettype wire

// ===== servo_mode_select_and_status.sv
// Control mode selection, fault indication and rotation detection for the servo drive.
`timescale 1ns/10ps
`default_nettype none
module servo_mode_select_and_status (
  input  wire logic                             ref_clk,
  input  wire logic                             reset,
  input  wire logic [3:0]                       control_mode_config,
  input  wire logic                             fwd_limit_select_n,
  input  wire logic                             rev_limit_select_n,
  input  wire logic                             mode_switch_n,
  input  wire logic                             fault_detected,
  input  wire logic                             fault_clear_n,
  input  wire logic                             panel_fault_clear,
  input  wire logic [servo_io_pkg::SPEED_W-1:0] motor_speed_rpm,
  input  wire logic [servo_io_pkg::THRESH_W-1:0] rotation_detect_threshold,
  input  wire logic                             threshold_load,
  output servo_io_pkg::ctrl_mode_e              active_mode,
  output logic                                  alternate_active,
  output logic                                  fault_indication,
  output logic                                  rotation_detected_n,
  output logic                                  panel_rotation_led,
  output logic [servo_io_pkg::THRESH_W-1:0]     threshold_in_use
);
  import servo_io_pkg::*;

  logic [3:0] pins_sync;
  logic       fwd_s, rev_s, switch_s, clear_s;

  pin_sync #(.WIDTH(4)) u_pin_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pin_in  ({fault_clear_n, mode_switch_n, rev_limit_select_n, fwd_limit_select_n}),
    .pin_out (pins_sync)
  );

  assign fwd_s    = pins_sync[0];
  assign rev_s    = pins_sync[1];
  assign switch_s = pins_sync[2];
  assign clear_s  = pins_sync[3];

  // Mode selection.
  ctrl_mode_e mode_q, mode_d;
  logic       alt_q, alt_d;
  logic       contact_alt;

  // The limit selects double as the switch request only for digits 4 to 6.
  assign contact_alt = fwd_s && rev_s;

  always_comb begin
    mode_d = MODE_OTHER;
    alt_d  = 1'b0;
    unique case (control_mode_config)
      DIGIT_SPD_SPD: begin
        alt_d  = contact_alt;
        mode_d = alt_d ? MODE_SPEED_ANALOG : MODE_SPEED_CONTACT;
      end
      DIGIT_SPD_POS: begin
        alt_d  = contact_alt;
        mode_d = alt_d ? MODE_POSITION_PULSE : MODE_SPEED_CONTACT;
      end
      DIGIT_SPD_TRQ: begin
        alt_d  = contact_alt;
        mode_d = alt_d ? MODE_TORQUE_ANALOG : MODE_SPEED_CONTACT;
      end
      DIGIT_POS_SPD: begin
        alt_d  = !switch_s;
        mode_d = alt_d ? MODE_SPEED_ANALOG : MODE_POSITION_PULSE;
      end
      DIGIT_POS_TRQ: begin
        alt_d  = !switch_s;
        mode_d = alt_d ? MODE_TORQUE_ANALOG : MODE_POSITION_PULSE;
      end
      DIGIT_TRQ_SPD: begin
        alt_d  = !switch_s;
        mode_d = alt_d ? MODE_SPEED_ANALOG : MODE_TORQUE_ANALOG;
      end
      DIGIT_SPD_ZCL: begin
        alt_d  = !switch_s;
        mode_d = alt_d ? MODE_ZERO_CLAMP : MODE_SPEED_ANALOG;
      end
      DIGIT_POS_INH: begin
        alt_d  = !switch_s;
        mode_d = alt_d ? MODE_POSITION_INHIBIT : MODE_POSITION_PULSE;
      end
      DIGIT_POS_CON: mode_d = MODE_POSITION_CONTACT;
      DIGIT_SPD_PAR: mode_d = MODE_SPEED_PARAM;
      DIGIT_SPECIAL: mode_d = MODE_SPECIAL;
      default:       mode_d = MODE_OTHER;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_q <= MODE_OTHER;
      alt_q  <= 1'b0;
    end else begin
      mode_q <= mode_d;
      alt_q  <= alt_d;
    end
  end

  assign active_mode      = mode_q;
  assign alternate_active = alt_q;

  // Fault latch. A new fault wins over a clear in the same cycle, so an
  // event is never lost while the clear pin is still held low.
  logic fault_q, fault_d;

  always_comb begin
    fault_d = fault_q;
    if (!clear_s || panel_fault_clear) begin
      fault_d = 1'b0;
    end
    if (fault_detected) begin
      fault_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  assign fault_indication = fault_q;

  // Threshold and rotation detection. Out-of-range loads are ignored so the
  // threshold never leaves 0 to 3000 rpm.
  logic [THRESH_W-1:0] thr_q, thr_d;
  logic                rot_q, rot_d;

  always_comb begin
    thr_d = thr_q;
    if (threshold_load && (rotation_detect_threshold <= THRESH_MAX)) begin
      thr_d = rotation_detect_threshold;
    end
    // Compared against the new value in the same cycle so a change applies at once.
    rot_d = motor_speed_rpm > SPEED_W'(thr_d);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      thr_q <= THRESH_DEFAULT;
      rot_q <= 1'b0;
    end else begin
      thr_q <= thr_d;
      rot_q <= rot_d;
    end
  end

  assign rotation_detected_n = !rot_q;
  assign panel_rotation_led  = rot_q;
  assign threshold_in_use    = thr_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_fault_set_wins: assert property (
    fault_detected |=> fault_indication)
    else $error("Fault event did not raise the fault output.");

  a_fault_pin_clear: assert property (
    (!clear_s && !fault_detected && !panel_fault_clear) ##1 !fault_detected [*2]
      |-> !fault_indication)
    else $error("Held fault clear did not clear the fault.");

  a_fault_holds: assert property (
    (fault_indication && clear_s && !panel_fault_clear) |=> fault_indication)
    else $error("Fault dropped without a clear.");

  a_panel_clear: assert property (
    (panel_fault_clear && !fault_detected) |=> !fault_indication)
    else $error("Panel clear did not clear the fault.");

  // The output registers the comparison of the previous cycle, so the
  // expectation is built from the sampled speed and threshold of that cycle.
  a_rotation_cmp: assert property (
    (!threshold_load && $stable(motor_speed_rpm))
      |=> (rotation_detected_n ==
           !($past(motor_speed_rpm) > SPEED_W'($past(threshold_in_use)))))
    else $error("Rotation output disagrees with the speed comparison.");

  a_rotation_equal: assert property (
    (!threshold_load && motor_speed_rpm == SPEED_W'(threshold_in_use))
      |=> rotation_detected_n)
    else $error("Speed equal to threshold reported as rotating.");

  a_threshold_load: assert property (
    (threshold_load && rotation_detect_threshold <= THRESH_MAX)
      |=> threshold_in_use == $past(rotation_detect_threshold))
    else $error("Valid threshold was not taken.");

  a_threshold_range: assert property (
    threshold_in_use <= THRESH_MAX)
    else $error("Threshold left its legal range.");

  a_mode_contact_alt: assert property (
    (control_mode_config == DIGIT_SPD_POS && fwd_s && rev_s)
      |=> active_mode == MODE_POSITION_PULSE && alternate_active)
    else $error("Digit 5 did not switch with both limit selects high.");

  a_mode_contact_pri: assert property (
    (control_mode_config == DIGIT_SPD_SPD && !(fwd_s && rev_s))
      |=> active_mode == MODE_SPEED_CONTACT)
    else $error("Digit 4 left contact speed control while a select was low.");

  a_panel_mirror: assert property (
    panel_rotation_led != rotation_detected_n)
    else $error("Panel rotation state disagrees with the output.");
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench for mode selection, fault indication and rotation detection.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import servo_io_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  cfg = 4'h0;
  logic [1:0]  limit_high = 2'b11;
  logic        alt_req = 1'b0;
  logic        clear_req = 1'b0;
  logic        cause_active = 1'b0;
  logic        fault_detected = 1'b0;
  logic        panel_clr = 1'b0;
  logic [15:0] speed = 16'h0000;
  logic [11:0] thr = 12'h000;
  logic        thr_load = 1'b0;
  wire logic   fwd_n, rev_n, sw_n, clr_n;
  ctrl_mode_e  active_mode;
  logic        alt_act, fault_ind, rot_n, rot_led;
  logic [11:0] thr_use;
  int          bad_count = 0;
  int          tests_run = 0;

  always #4 ref_clk = ~ref_clk;

  host_ctrl_model partner (.ref_clk(ref_clk), .limit_high(limit_high), .alt_req(alt_req),
    .clear_req(clear_req), .cause_active(cause_active), .fwd_limit_select_n(fwd_n),
    .rev_limit_select_n(rev_n), .mode_switch_n(sw_n), .fault_clear_n(clr_n));

  servo_mode_select_and_status uut (.ref_clk(ref_clk), .reset(reset),
    .control_mode_config(cfg), .fwd_limit_select_n(fwd_n), .rev_limit_select_n(rev_n),
    .mode_switch_n(sw_n), .fault_detected(fault_detected), .fault_clear_n(clr_n),
    .panel_fault_clear(panel_clr), .motor_speed_rpm(speed), .rotation_detect_threshold(thr),
    .threshold_load(thr_load), .active_mode(active_mode), .alternate_active(alt_act),
    .fault_indication(fault_ind), .rotation_detected_n(rot_n),
    .panel_rotation_led(rot_led), .threshold_in_use(thr_use));

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic do_reset;
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
  endtask

  task automatic pulse(input logic fd, input logic pc);
    @(posedge ref_clk);
    fault_detected <= fd;
    panel_clr <= pc;
    @(posedge ref_clk);
    fault_detected <= 1'b0;
    panel_clr <= 1'b0;
    #1;
  endtask

  function automatic ctrl_mode_e exp_mode(input logic [3:0] d, input logic a);
    case (d)
      4'h4: return a ? MODE_SPEED_ANALOG : MODE_SPEED_CONTACT;
      4'h5: return a ? MODE_POSITION_PULSE : MODE_SPEED_CONTACT;
      4'h6: return a ? MODE_TORQUE_ANALOG : MODE_SPEED_CONTACT;
      4'h7: return a ? MODE_SPEED_ANALOG : MODE_POSITION_PULSE;
      4'h8: return a ? MODE_TORQUE_ANALOG : MODE_POSITION_PULSE;
      4'h9: return a ? MODE_SPEED_ANALOG : MODE_TORQUE_ANALOG;
      4'ha: return a ? MODE_ZERO_CLAMP : MODE_SPEED_ANALOG;
      4'hb: return a ? MODE_POSITION_INHIBIT : MODE_POSITION_PULSE;
      4'hc: return MODE_POSITION_CONTACT;
      4'hd: return MODE_SPEED_PARAM;
      4'he: return MODE_SPECIAL;
      default: return MODE_OTHER;
    endcase
  endfunction

  task automatic t_modes;
    for (int d = 0; d < 16; d++) begin
      for (int a = 0; a < 2; a++) begin
        @(posedge ref_clk);
        cfg <= 4'(d);
        limit_high <= a[0] ? 2'b11 : 2'b00;
        alt_req <= a[0];
        step(8);
        chk(active_mode === exp_mode(4'(d), a[0]), "mode");
        if (d >= 4 && d <= 11) chk(alt_act === a[0], "alt flag");
        else chk(alt_act === 1'b0, "alt flag idle");
      end
    end
    @(posedge ref_clk);
    cfg <= DIGIT_SPD_POS;
    limit_high <= 2'b10;
    step(8);
    chk(active_mode === MODE_SPEED_CONTACT, "one select high");
    $display("test modes done");
  endtask

  task automatic wait_clear;
    int n;
    for (n = 0; n < 12 && fault_ind !== 1'b0; n++) step(1);
    chk(fault_ind === 1'b0, "pin clear");
  endtask

  task automatic t_fault;
    chk(fault_ind === 1'b0, "normal level");
    pulse(1'b1, 1'b0);
    chk(fault_ind === 1'b1, "fault set");
    @(posedge ref_clk);
    cause_active <= 1'b1;
    clear_req <= 1'b1;
    step(10);
    chk(fault_ind === 1'b1, "fault held");
    @(posedge ref_clk);
    cause_active <= 1'b0;
    wait_clear();
    @(posedge ref_clk);
    clear_req <= 1'b0;
    step(8);
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    chk(fault_ind === 1'b0, "panel clear");
    pulse(1'b1, 1'b1);
    chk(fault_ind === 1'b1, "set wins");
    do_reset();
    chk(fault_ind === 1'b0, "power-up clear");
    $display("test fault done");
  endtask

  task automatic rot(input logic [15:0] s, input logic ld, input logic [11:0] th,
                     input logic r, input logic [11:0] et);
    @(posedge ref_clk);
    speed <= s;
    thr_load <= ld;
    thr <= th;
    @(posedge ref_clk);
    thr_load <= 1'b0;
    #1;
    chk(rot_n === ~r && rot_led === r, "rotation");
    chk(thr_use === et, "threshold");
  endtask

  task automatic t_rotation;
    chk(thr_use === THRESH_DEFAULT, "default");
    rot(16'h0014, 1'b0, 12'h000, 1'b0, 12'h014);
    rot(16'h0015, 1'b0, 12'h000, 1'b1, 12'h014);
    rot(16'h0065, 1'b1, 12'h064, 1'b1, 12'h064);
    rot(16'h0064, 1'b0, 12'h000, 1'b0, 12'h064);
    rot(16'h0bb8, 1'b1, THRESH_MAX, 1'b0, THRESH_MAX);
    rot(16'h0bb9, 1'b1, 12'hbb9, 1'b1, THRESH_MAX);
    rot(16'h0000, 1'b1, 12'h000, 1'b0, 12'h000);
    rot(16'h0001, 1'b0, 12'h000, 1'b1, 12'h000);
    $display("test rotation done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    step(1);
    t_rotation();
    t_fault();
    t_modes();
    report_and_stop();
  end
endmodule
`default_nettype wire
